//--- hdl/rcc_pkg.sv
// Purpose: Constants and state layout for the reset and clock controller.
// Assumes: 100 MHz system clock; registers reached over APB.
// Notes: Register offsets are byte addresses of aligned 32-bit words.
package rcc_pkg;
    localparam int CLK_MHZ = 100;
    localparam int CLK_PS = 1000000 / CLK_MHZ;
    localparam int GLITCH_NS = 3;
    // Least pulse width in samples, rounded up, never below one.
    localparam int GLITCH_RAW = (GLITCH_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int GLITCH_CYC = (GLITCH_RAW < 1) ? 1 : GLITCH_RAW;
    localparam logic [3:0] GLITCH_LIM = GLITCH_CYC[3:0];
    localparam logic [3:0] PHASE_MAX = 4'hF;
    localparam logic [7:0] RST_HOLD = 8'h10;
    localparam logic [7:0] RC_SLOW_DIV = 8'hFF;

    localparam logic [7:0] RST_REQ_OFS = 8'h00;
    localparam logic [7:0] CPU_CLK_OFS = 8'h04;
    localparam logic [7:0] RTC_CLK_OFS = 8'h08;
    localparam logic [7:0] STATUS_OFS = 8'h0C;

    // Reset request and level indices.
    localparam int LV_CORE0 = 0;
    localparam int LV_CORE1 = 1;
    localparam int LV_DOMAIN = 2;
    localparam int LV_SYSTEM = 3;
    localparam int LV_CHIP = 4;
    localparam int NLV = 5;

    // Clock input indices.
    localparam int CK_XTAL = 0;
    localparam int CK_FRC = 1;
    localparam int CK_PLL = 2;
    localparam int CK_X32K = 3;
    localparam int CK_SRC = 4;
    localparam int NCK = 5;

    localparam logic [1:0] CPU_SRC_XTAL = 2'h0;
    localparam logic [1:0] CPU_SRC_FRC = 2'h1;
    localparam logic [1:0] CPU_SRC_PLL = 2'h2;
    localparam logic [1:0] SLOW_SRC_X32K = 2'h0;
    localparam logic [1:0] SLOW_SRC_SRC = 2'h1;
    localparam logic [1:0] SLOW_SRC_FRC256 = 2'h2;
    localparam logic FAST_SRC_XTAL2 = 1'b0;
    localparam logic FAST_SRC_FRC = 1'b1;

    // Register fields and CPU clock reset values.
    localparam int CPU_DIVEN_BIT = 2;
    localparam int CPU_DIV_LSB = 8;
    localparam logic [7:0] CPU_DIV_RST = 8'h02;
    localparam logic CPU_DIVEN_RST = 1'b1;
    localparam int FAST_SEL_BIT = 2;
    localparam int GLITCH_BIT = 0;
    localparam int RSTACT_LSB = 8;

    typedef struct packed {
        logic ready;
        logic err;
        logic [31:0] rdata;
        logic [1:0] cpu_src;
        logic div_en;
        logic [7:0] div_val;
        logic [1:0] slow_src;
        logic fast_src;
        logic [NCK-1:0] s1;
        logic [NCK-1:0] s2;
        logic [NCK-1:0] s3;
        logic [NCK-1:0] stab;
        logic [3:0] phase;
        logic glitch;
        logic xt_half;
        logic [7:0] rc_div;
        logic [7:0] cpu_cnt;
        logic [NLV-1:0][7:0] rst_cnt;
        logic [NLV-1:0] rst_n;
        logic sec_rst_n;
        logic cpu_clk_en;
        logic slow_en;
        logic fast_en;
    } rcc_state_t;
endpackage

//--- hdl/rcc_top.sv
// Purpose: Reset level sequencing and clock source selection.
// Assumes: Clock sources arrive as pins sampled on the system clock.
// Notes: Derived clocks leave as one-cycle enable pulses.
`timescale 1ns/1ps
module rcc_top
    import rcc_pkg::*;
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic main_crystal_clock,
    input wire logic fast_rc_clock,
    input wire logic pll_clock,
    input wire logic slow_crystal_clock,
    input wire logic slow_rc_clock,
    input wire logic [1:0] hw_core_rst_req,
    input wire logic hw_domain_rst_req,
    input wire logic hw_system_rst_req,
    input wire logic hw_chip_rst_req,
    output logic first_core_rst_n,
    output logic second_core_rst_n,
    output logic secure_regs_rst_n,
    output logic domain_rst_n,
    output logic rtc_rst_n,
    output logic chip_rst_n,
    output logic cpu_clk_en,
    output logic rtc_slow_clk_en,
    output logic rtc_fast_clk_en
);
    rcc_state_t st_reg;
    rcc_state_t st_next;

    logic [NCK-1:0] pins;
    assign pins = {slow_rc_clock, slow_crystal_clock, pll_clock,
                   fast_rc_clock, main_crystal_clock};

    always_comb begin
        logic access;
        logic wr;
        logic [NLV-1:0] req;
        logic [NLV-1:0] eff;
        logic [NCK-1:0] settle;
        logic [NCK-1:0] rise;
        logic xt_edge;
        logic frc256;
        logic src_edge;
        logic cfg_change;
        logic slow_change;
        logic [31:0] rd;
        logic hit;
        access = 1'b0;
        wr = 1'b0;
        req = '0;
        eff = '0;
        settle = '0;
        rise = '0;
        xt_edge = 1'b0;
        frc256 = 1'b0;
        src_edge = 1'b0;
        cfg_change = 1'b0;
        slow_change = 1'b0;
        rd = '0;
        hit = 1'b0;
        st_next = st_reg;

        // Three-stage sampling; a change is accepted once stages 2 and 3
        // agree, so the first stage feeds only the second.
        st_next.s1 = pins;
        st_next.s2 = st_reg.s1;
        st_next.s3 = st_reg.s2;
        for (int i = 0; i < NCK; i++) begin
            settle[i] = (st_reg.s2[i] == st_reg.s3[i])
                && (st_reg.s3[i] != st_reg.stab[i]);
            if (settle[i]) begin
                st_next.stab[i] = st_reg.s3[i];
            end
            rise[i] = settle[i] && st_reg.s3[i];
        end

        // Pulse width watch on the crystal; a phase no longer than the
        // limit latches the block until cleared or a system reset. The
        // shortest phase the synchroniser can accept counts as one.
        if (settle[CK_XTAL]) begin
            if (st_reg.phase <= GLITCH_LIM) begin
                st_next.glitch = 1'b1;
            end
            st_next.phase = '0;
        end else if (st_reg.phase != PHASE_MAX) begin
            st_next.phase = st_reg.phase + 4'h1;
        end
        xt_edge = rise[CK_XTAL] && !st_reg.glitch;

        // APB slave: one wait state, answer registered.
        access = psel && penable && !st_reg.ready;
        wr = access && pwrite;
        st_next.ready = access;
        st_next.err = 1'b0;
        case (paddr)
            RST_REQ_OFS: begin
                hit = 1'b1;
                rd = '0;
            end
            CPU_CLK_OFS: begin
                hit = 1'b1;
                rd[1:0] = st_reg.cpu_src;
                rd[CPU_DIVEN_BIT] = st_reg.div_en;
                rd[CPU_DIV_LSB +: 8] = st_reg.div_val;
            end
            RTC_CLK_OFS: begin
                hit = 1'b1;
                rd[1:0] = st_reg.slow_src;
                rd[FAST_SEL_BIT] = st_reg.fast_src;
            end
            STATUS_OFS: begin
                hit = 1'b1;
                rd[GLITCH_BIT] = st_reg.glitch;
                rd[RSTACT_LSB +: NLV] = ~st_reg.rst_n;
            end
            default: begin
                hit = 1'b0;
                rd = '0;
            end
        endcase
        if (access) begin
            st_next.rdata = pwrite ? '0 : rd;
            st_next.err = !hit;
        end

        if (wr && hit) begin
            case (paddr)
                RST_REQ_OFS: begin
                    req = pwdata[NLV-1:0];
                end
                CPU_CLK_OFS: begin
                    st_next.cpu_src = pwdata[1:0];
                    st_next.div_en = pwdata[CPU_DIVEN_BIT];
                    st_next.div_val = pwdata[CPU_DIV_LSB +: 8];
                    cfg_change = 1'b1;
                end
                RTC_CLK_OFS: begin
                    st_next.slow_src = pwdata[1:0];
                    st_next.fast_src = pwdata[FAST_SEL_BIT];
                    slow_change = 1'b1;
                end
                STATUS_OFS: begin
                    // A glitch seen in the same cycle wins over the clear.
                    if (pwdata[GLITCH_BIT]
                        && !(settle[CK_XTAL]
                        && st_reg.phase <= GLITCH_LIM)) begin
                        st_next.glitch = 1'b0;
                    end
                end
                default: begin
                    req = '0;
                end
            endcase
        end

        // Hardware requests join the software ones.
        req[LV_CORE0] = req[LV_CORE0] | hw_core_rst_req[0];
        req[LV_CORE1] = req[LV_CORE1] | hw_core_rst_req[1];
        req[LV_DOMAIN] = req[LV_DOMAIN] | hw_domain_rst_req;
        req[LV_SYSTEM] = req[LV_SYSTEM] | hw_system_rst_req;
        req[LV_CHIP] = req[LV_CHIP] | hw_chip_rst_req;

        // Levels nest: each wider level drags every narrower one.
        eff[LV_CHIP] = req[LV_CHIP];
        eff[LV_SYSTEM] = req[LV_SYSTEM] | eff[LV_CHIP];
        eff[LV_DOMAIN] = req[LV_DOMAIN] | eff[LV_SYSTEM];
        eff[LV_CORE0] = req[LV_CORE0] | eff[LV_DOMAIN];
        eff[LV_CORE1] = req[LV_CORE1] | eff[LV_DOMAIN];

        // Each level is stretched to a fixed hold count before release.
        for (int i = 0; i < NLV; i++) begin
            if (eff[i]) begin
                st_next.rst_cnt[i] = RST_HOLD;
            end else if (st_reg.rst_cnt[i] != '0) begin
                st_next.rst_cnt[i] = st_reg.rst_cnt[i] - 8'h01;
            end
            st_next.rst_n[i] = (st_next.rst_cnt[i] == '0);
        end
        st_next.sec_rst_n = st_next.rst_n[LV_CORE0];

        // A first core reset restores the default CPU clock.
        if (eff[LV_CORE0]) begin
            st_next.cpu_src = CPU_SRC_XTAL;
            st_next.div_en = CPU_DIVEN_RST;
            st_next.div_val = CPU_DIV_RST;
            cfg_change = 1'b1;
        end
        if (eff[LV_SYSTEM]) begin
            st_next.slow_src = SLOW_SRC_X32K;
            st_next.fast_src = FAST_SRC_XTAL2;
            st_next.glitch = 1'b0;
            slow_change = 1'b1;
        end

        // Slow divider of the fast RC; restarted on a slow switch so the
        // first period after it is whole.
        if (slow_change) begin
            st_next.rc_div = '0;
        end else if (rise[CK_FRC]) begin
            st_next.rc_div = st_reg.rc_div + 8'h01;
            frc256 = (st_reg.rc_div == RC_SLOW_DIV);
        end
        if (xt_edge) begin
            st_next.xt_half = !st_reg.xt_half;
        end

        case (st_reg.cpu_src)
            CPU_SRC_XTAL: src_edge = xt_edge;
            CPU_SRC_FRC: src_edge = rise[CK_FRC];
            CPU_SRC_PLL: src_edge = rise[CK_PLL];
            default: src_edge = 1'b0;
        endcase

        // Divider restart on any change avoids a runt first period.
        st_next.cpu_clk_en = 1'b0;
        if (cfg_change) begin
            st_next.cpu_cnt = '0;
        end else if (src_edge) begin
            if (!st_reg.div_en || st_reg.div_val <= 8'h01) begin
                st_next.cpu_clk_en = 1'b1;
            end else if (st_reg.cpu_cnt >= st_reg.div_val - 8'h01) begin
                st_next.cpu_cnt = '0;
                st_next.cpu_clk_en = 1'b1;
            end else begin
                st_next.cpu_cnt = st_reg.cpu_cnt + 8'h01;
            end
        end

        st_next.slow_en = 1'b0;
        if (!slow_change) begin
            case (st_reg.slow_src)
                SLOW_SRC_X32K: st_next.slow_en = rise[CK_X32K];
                SLOW_SRC_SRC: st_next.slow_en = rise[CK_SRC];
                SLOW_SRC_FRC256: st_next.slow_en = frc256;
                default: st_next.slow_en = 1'b0;
            endcase
        end
        st_next.fast_en = 1'b0;
        if (!slow_change) begin
            if (st_reg.fast_src == FAST_SRC_FRC) begin
                st_next.fast_en = rise[CK_FRC];
            end else begin
                st_next.fast_en = xt_edge && !st_reg.xt_half;
            end
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            st_reg <= '0;
            st_reg.phase <= PHASE_MAX;
            st_reg.cpu_src <= CPU_SRC_XTAL;
            st_reg.div_en <= CPU_DIVEN_RST;
            st_reg.div_val <= CPU_DIV_RST;
            st_reg.slow_src <= SLOW_SRC_X32K;
            st_reg.fast_src <= FAST_SRC_XTAL2;
            st_reg.rst_cnt <= {NLV{RST_HOLD}};
        end else begin
            st_reg <= st_next;
        end
    end

    assign prdata = st_reg.rdata;
    assign pready = st_reg.ready;
    assign pslverr = st_reg.err;
    assign first_core_rst_n = st_reg.rst_n[LV_CORE0];
    assign second_core_rst_n = st_reg.rst_n[LV_CORE1];
    assign secure_regs_rst_n = st_reg.sec_rst_n;
    assign domain_rst_n = st_reg.rst_n[LV_DOMAIN];
    assign rtc_rst_n = st_reg.rst_n[LV_SYSTEM];
    assign chip_rst_n = st_reg.rst_n[LV_CHIP];
    assign cpu_clk_en = st_reg.cpu_clk_en;
    assign rtc_slow_clk_en = st_reg.slow_en;
    assign rtc_fast_clk_en = st_reg.fast_en;
endmodule

//--- testbench/rcc_top_sva.sv
// Purpose: Assertions on reset nesting, reset holds and clock pulses.
// Assumes: Sees only the ports of rcc_top, one clock domain.
// Notes: Bound to every rcc_top instance below the module.
`timescale 1ns/1ps
module rcc_chk (
    input wire logic clock,
    input wire logic resetn,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [1:0] hw_core_rst_req,
    input wire logic hw_domain_rst_req,
    input wire logic hw_system_rst_req,
    input wire logic hw_chip_rst_req,
    input wire logic first_core_rst_n,
    input wire logic second_core_rst_n,
    input wire logic secure_regs_rst_n,
    input wire logic domain_rst_n,
    input wire logic rtc_rst_n,
    input wire logic chip_rst_n,
    input wire logic cpu_clk_en,
    input wire logic rtc_fast_clk_en
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);
    sec_follow_a: assert property (secure_regs_rst_n == first_core_rst_n)
        else $error("secure reset differs from first core reset");
    chip_nest_a: assert property (!chip_rst_n |-> !rtc_rst_n)
        else $error("chip reset without rtc reset");
    sys_nest_a: assert property (!rtc_rst_n |-> !domain_rst_n)
        else $error("rtc reset without domain reset");
    dom_nest_a: assert property (!domain_rst_n |->
        !first_core_rst_n && !second_core_rst_n)
        else $error("domain reset left a core running");
    core_hw_a: assert property (hw_core_rst_req[1] |=> !second_core_rst_n [*8])
        else $error("second core reset not held");
    dom_hw_a: assert property (hw_domain_rst_req |=> !domain_rst_n)
        else $error("domain request ignored");
    sys_hw_a: assert property (hw_system_rst_req |=> !rtc_rst_n)
        else $error("system request ignored");
    chip_hw_a: assert property ($rose(hw_chip_rst_req) |=> !chip_rst_n)
        else $error("chip request ignored");
    rel_hold_a: assert property ($rose(first_core_rst_n) |->
        $past(first_core_rst_n, 8) == 1'b0)
        else $error("first core reset released too soon");
    no_runt_a: assert property (cpu_clk_en |=> !cpu_clk_en)
        else $error("back to back cpu clock pulses");
    fast_runt_a: assert property (rtc_fast_clk_en |=> !rtc_fast_clk_en)
        else $error("back to back fast clock pulses");
    err_pulse_a: assert property (pslverr |-> pready ##1 !pready)
        else $error("error without one-cycle ready");
    cover property (hw_chip_rst_req ##1 !chip_rst_n);
    cover property (cpu_clk_en);
    cover property (pslverr);
endmodule
bind rcc_top rcc_chk chk_u (.*);

//--- testbench/rcc_tb_top.sv
// Purpose: Self-checking bench for the reset and clock controller.
// Assumes: Clock sources are slow square waves made on the system clock.
// Notes: Clock pulse counts allow one pulse of slack for synchroniser phase; glitch counts allow none.
`timescale 1ns/1ps
module rcc_tb_top;
import rcc_pkg::*;
logic clock = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
logic [7:0] paddr = '0;
logic [31:0] pwdata = '0, prdata;
logic pready, pslverr, fcr, scr, srr, dr, rr, cr, ce, sle, fae;
logic [4:0] src = '0;
logic [1:0] hcr = '0;
logic hd = 0, hs = 0, hc = 0;
bit xrun = 1;
int error_cnt = 0, n_checks = 0, cnt[5], edg[5];
int hp[5] = '{5, 3, 2, 8, 6};
logic [4:0] m[5] = '{5'h01, 5'h02, 5'h07, 5'h0F, 5'h1F};
wire [2:0] ens = {fae, sle, ce};
wire [4:0] rv = {cr, rr, dr, scr, fcr};
rcc_top dut_u (.clock(clock), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .main_crystal_clock(src[0]), .fast_rc_clock(src[1]),
    .pll_clock(src[2]), .slow_crystal_clock(src[3]),
    .slow_rc_clock(src[4]), .hw_core_rst_req(hcr), .hw_domain_rst_req(hd),
    .hw_system_rst_req(hs), .hw_chip_rst_req(hc), .first_core_rst_n(fcr),
    .second_core_rst_n(scr), .secure_regs_rst_n(srr), .domain_rst_n(dr),
    .rtc_rst_n(rr), .chip_rst_n(cr), .cpu_clk_en(ce),
    .rtc_slow_clk_en(sle), .rtc_fast_clk_en(fae));
initial begin
    forever #5 clock = ~clock;
end
// Each source toggles every hp cycles; the crystal stops while xrun is low.
always @(posedge clock) begin
    for (int i = 0; i < 5; i++) begin
        if (i > 0 || xrun) begin
            if (cnt[i] == hp[i] - 1) begin
                cnt[i] <= 0;
                src[i] <= ~src[i];
                if (!src[i]) edg[i] <= edg[i] + 1;
            end else cnt[i] <= cnt[i] + 1;
        end
    end
end
task wrap_up;
    $display("checks=%0d errors=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
endtask
task chk32(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
        error_cnt++;
        $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
endtask
task chkn(input int g, input int e, input int tol);
    n_checks++;
    if (g < e - tol || g > e + tol) begin
        error_cnt++;
        $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
endtask
task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] r, output logic er);
    int k;
    @(posedge clock);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1;
    k = 0;
    do begin
        @(posedge clock);
        k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) chk32(32'h0, 32'h1);
    r = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
endtask
task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1, a, d, r, e);
    chk32({31'h0, e}, 32'h0);
endtask
task rdc(input logic [7:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic e;
    apb(0, a, 32'h0, r, e);
    chk32(r, x);
    chk32({31'h0, e}, {31'h0, xe});
endtask
task meas(input int e, input int s, input int dv, input int n, input int t);
    int p, e0;
    p = 0;
    repeat (30) @(posedge clock);
    e0 = edg[s];
    repeat (n) begin
        @(posedge clock);
        if (ens[e] === 1'b1) p++;
    end
    chkn(p, (edg[s] - e0) / dv, t);
endtask
task t_regs;
    rdc(CPU_CLK_OFS, 32'h0000_0204, 0);
    rdc(RTC_CLK_OFS, 32'h0, 0);
    rdc(8'h10, 32'h0, 1);
    rdc(RST_REQ_OFS, 32'h0, 0);
    $display("t_regs done");
endtask
task t_clk;
    meas(0, CK_XTAL, 2, 400, 1);
    wr(CPU_CLK_OFS, 32'h0000_0002);
    meas(0, CK_PLL, 1, 400, 1);
    wr(CPU_CLK_OFS, 32'h0000_0405);
    meas(0, CK_FRC, 4, 400, 1);
    wr(CPU_CLK_OFS, 32'h0);
    meas(0, CK_XTAL, 1, 400, 1);
    wr(RTC_CLK_OFS, 32'h1);
    meas(1, CK_SRC, 1, 400, 1);
    meas(2, CK_XTAL, 2, 400, 1);
    wr(RTC_CLK_OFS, 32'h6);
    meas(2, CK_FRC, 1, 400, 1);
    meas(1, CK_FRC, 256, 3100, 1);
    wr(RTC_CLK_OFS, 32'h0);
    meas(1, CK_X32K, 1, 400, 1);
    $display("t_clk done");
endtask
task t_glitch;
    xrun <= 0;
    @(posedge clock);
    src[0] <= 0;
    repeat (10) @(posedge clock);
    src[0] <= 1;
    repeat (2) @(posedge clock);
    src[0] <= 0;
    repeat (10) @(posedge clock);
    xrun <= 1;
    rdc(STATUS_OFS, 32'h1, 0);
    meas(0, CK_XTAL, 1000, 400, 0);
    meas(2, CK_XTAL, 1000, 400, 0);
    wr(STATUS_OFS, 32'h1);
    rdc(STATUS_OFS, 32'h0, 0);
    $display("t_glitch done");
endtask
task t_sw;
    for (int b = 0; b < 5; b++) begin
        wr(CPU_CLK_OFS, 32'h0000_0102);
        wr(RTC_CLK_OFS, 32'h4);
        wr(RST_REQ_OFS, 32'h1 << b);
        repeat (2) @(posedge clock);
        chk32({27'h0, rv}, {27'h0, ~m[b]});
        repeat (20) @(posedge clock);
        chk32({27'h0, rv}, 32'h1F);
        rdc(CPU_CLK_OFS, b == 1 ? 32'h102 : 32'h204, 0);
        rdc(RTC_CLK_OFS, b > 2 ? 32'h0 : 32'h4, 0);
    end
    $display("t_sw done");
endtask
task t_hw;
    for (int b = 0; b < 5; b++) begin
        @(posedge clock);
        {hc, hs, hd, hcr} <= 5'h01 << b;
        @(posedge clock);
        {hc, hs, hd, hcr} <= 5'h00;
        repeat (2) @(posedge clock);
        chk32({27'h0, rv}, {27'h0, ~m[b]});
        repeat (20) @(posedge clock);
    end
    $display("t_hw done");
endtask
initial begin
    #300000;
    error_cnt++;
    wrap_up;
end
initial begin
    repeat (4) @(posedge clock);
    resetn <= 1;
    repeat (20) @(posedge clock);
    t_regs;
    t_clk;
    t_glitch;
    t_sw;
    t_hw;
    wrap_up;
end
endmodule
